// ---- tb.sv ----
/* Self-checking testbench for the timing master configuration bank.
   Assumes tmcr_regs, its map header and the bound checker are compiled. */
`timescale 1ns/10ps
`include "tmcr_map.vh"
module tb;
    localparam [31:0] TO = 32'd16; // Short alarm timeout keeps the run brief
    reg clk = 0, rst = 1, wr = 0, rd = 0, pin = 1, lock = 0, aps = 0, act;
    reg [7:0] addr = 8'h00, wdata = 8'h00, v;
    reg [3:0] src = 4'h0, refs = 4'h0, rcode = 4'h0;
    reg [8:0] aset = 9'h000, acan = 9'h000;
    wire [7:0] rdata;
    wire [8:0] alarm;
    wire [11:0] khz;
    wire [3:0] fin;
    wire sw, edg, zho, mrev, arev, ofm, afm, auf, fact, nosw, e5, e4, e5b, e4b, f3b;
    integer n_errors = 0, checked = 0, i, n;
    tmcr_regs #(.ALARM_TIMEOUT(TO)) DUT (
        .MCLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .RATE_SELECT_PIN_I(pin), .SYNC_SOURCE_I(src),
        .MAIN_SELECTED_REF_I(refs), .MAIN_LOCKED_I(lock), .INPUT_RATE_CODE_I(rcode),
        .AUX_APLL_SOURCE_I(aps), .PHASE_ALARM_SET_I(aset), .PHASE_ALARM_CANCEL_I(acan),
        .REG_RDATA_O(rdata), .EXT_SYNC_WATCH_O(sw), .PHASE_ALARM_O(alarm),
        .OSC_EDGE_FALLING_O(edg), .ZERO_OFFSET_HOLDOVER_O(zho), .NOMINAL_KHZ_O(khz),
        .MAIN_REVERTIVE_O(mrev), .AUX_REVERTIVE_O(arev), .OUTPUTS_FROM_MAIN_O(ofm),
        .AUX_APLL_FROM_MAIN_O(afm), .AUX_APLL_USE_INPUT_RATE_CODE_O(auf), .AUX_FORCE_ACTIVE_O(fact),
        .AUX_FORCE_INPUT_O(fin), .AUX_NO_SWITCH_O(nosw), .OUT5_ENABLE_O(e5),
        .OUT4_ENABLE_O(e4), .OUT5B_ENABLE_O(e5b), .OUT4B_ENABLE_O(e4b),
        .OUT3B_CLOCK_FN_O(f3b));
    // ****************************************
    // Clock, tasks and watchdog
    // ****************************************
    initial begin
        forever #25 clk = ~clk;
    end
    // Inputs move 1 ns after the edge so sampling never races
    task tick;
        @(posedge clk);
        #1;
    endtask
    task wt(input integer k);
        repeat (k) tick;
    endtask
    task chk(input [11:0] got, input [11:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Strobe stays low a full cycle so back-to-back calls never clash
    task wreg(input [7:0] a, input [7:0] d);
        addr = a;
        wdata = d;
        wr = 1;
        tick;
        wr = 0;
        tick;
    endtask
    task rreg(input [7:0] a, input [7:0] exp);
        addr = a;
        rd = 1;
        tick;
        rd = 0;
        tick;
        chk({4'h0, rdata}, {4'h0, exp});
    endtask
    // Strap is set before reset so the synchroniser sees a stable level
    task reset(input p);
        pin = p;
        rst = 1;
        wt(20);
        rst = 0;
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Several times the expected run, so a stuck wait cannot hang
    initial begin
        repeat (3000) @(posedge clk);
        n_errors = n_errors + 1;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up;
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        reset(1'b1);
        rreg(`TMCR_SYNC_HOLD_ADDR, `TMCR_SYNC_HOLD_RESET | 8'h04);
        rreg(`TMCR_AUX_PLL_ADDR, `TMCR_AUX_PLL_RESET);
        rreg(`TMCR_LEGACY_FMT_ADDR, `TMCR_LEGACY_FMT_RESET);
        rreg(`TMCR_OUT_EN_ADDR, `TMCR_OUT_EN_RESET);
        rreg(8'h38, 8'h00);
        chk({e5, e4, e5b, e4b, f3b, arev, mrev}, 12'h062);
        $display("test reset done");
        for (i = 0; i < 2; i = i + 1) begin
            v = i ? 8'h5a : 8'ha5;
            wreg(`TMCR_LEGACY_FMT_ADDR, v);
            rreg(`TMCR_LEGACY_FMT_ADDR, v);
            v = i ? 8'h00 : 8'h31;
            wreg(`TMCR_SYNC_HOLD_ADDR, v);
            rreg(`TMCR_SYNC_HOLD_ADDR, v | 8'h02);
            chk({edg, zho, mrev}, {v[5], v[4], v[0]});
            v = i ? 8'h00 : 8'hff;
            wreg(`TMCR_OUT_EN_ADDR, v);
            rreg(`TMCR_OUT_EN_ADDR, v & 8'h7f);
            chk({e5, e4, e5b, e4b, f3b}, v[6:2]);
            wreg(`TMCR_SYNC_HOLD_ADDR, i ? 8'h04 : 8'h00);
            rcode = `TMCR_RATE_CODE_T1E1;
            wt(2);
            chk(khz, i ? `TMCR_KHZ_T1 : `TMCR_KHZ_E1);
            rcode = 4'h2;
            wt(2);
            chk(khz, 12'h000);
        end
        $display("test registers done");
        for (i = 0; i < 16; i = i + 1) begin
            wreg(`TMCR_AUX_PLL_ADDR, i[7:0]);
            wt(1);
            act = (i >= 1 && i <= 6) || i == 8 || i == 9;
            chk({fact, nosw, fin}, {act, act, act ? i[3:0] : 4'h0});
        end
        for (i = 0; i < 4; i = i + 1) begin
            aps = i[0];
            wreg(`TMCR_AUX_PLL_ADDR, {i[1], 7'h00});
            wt(1);
            chk({ofm, auf, afm}, {i[1] & ~i[0], i[1] & ~i[0], i[1] | i[0]});
        end
        $display("test aux pll done");
        src = 4'hc;
        wreg(`TMCR_SYNC_HOLD_ADDR, 8'h88);
        wt(2);
        chk(sw, 1'b1);
        refs = 4'h2;
        wt(3);
        chk(sw, 1'b0);
        rreg(`TMCR_SYNC_HOLD_ADDR, 8'h82);
        wreg(`TMCR_SYNC_HOLD_ADDR, 8'h08);
        refs = 4'h3;
        wt(3);
        chk(sw, 1'b1);
        wreg(`TMCR_SYNC_HOLD_ADDR, 8'h00);
        wt(2);
        chk(sw, 1'b0);
        src = 4'h3;
        wreg(`TMCR_SYNC_HOLD_ADDR, 8'h88);
        for (i = 0; i < 3; i = i + 1) begin
            lock = (i != 0);
            refs = (i == 2) ? 4'h5 : 4'h3;
            wt(3);
            chk(sw, i == 1);
        end
        $display("test frame sync done");
        wreg(`TMCR_SYNC_HOLD_ADDR, 8'h40);
        aset = 9'h001;
        tick;
        aset = 9'h000;
        n = 0;
        while (alarm[0] === 1'b1 && n < 100) begin
            n = n + 1;
            tick;
        end
        chk(n[11:0], TO[11:0]);
        wreg(`TMCR_SYNC_HOLD_ADDR, 8'h00);
        aset = 9'h100;
        tick;
        aset = 9'h000;
        wt(3 * TO);
        chk(alarm[8], 1'b1);
        acan = 9'h100;
        tick;
        acan = 9'h000;
        tick;
        chk(alarm[8], 1'b0);
        $display("test phase alarm done");
        reset(1'b0);
        rreg(`TMCR_SYNC_HOLD_ADDR, `TMCR_SYNC_HOLD_RESET);
        $display("test strap done");
        wrap_up;
    end
endmodule

// ---- tmcr_map.vh ----
/*
 * Offsets, field positions, reset values and timing counts of the timing
 * master configuration register bank.
 * Assumes a 20 MHz master clock and a byte-wide processor register port.
 */
`ifndef TMCR_MAP_VH
`define TMCR_MAP_VH

`define TMCR_SYNC_HOLD_ADDR 8'h34
`define TMCR_AUX_PLL_ADDR 8'h35
`define TMCR_LEGACY_FMT_ADDR 8'h36
`define TMCR_OUT_EN_ADDR 8'h37

`define TMCR_SYNC_HOLD_RESET 8'hca
`define TMCR_AUX_PLL_RESET 8'h00
`define TMCR_LEGACY_FMT_RESET 8'h00
`define TMCR_OUT_EN_RESET 8'h60

`define TMCR_BIT_AUTO_GATE 7
`define TMCR_BIT_AUTOCLEAR 6
`define TMCR_BIT_OSC_EDGE 5
`define TMCR_BIT_ZERO_HOLD 4
`define TMCR_BIT_EXT_SYNC 3
`define TMCR_BIT_RATE_SEL 2
`define TMCR_BIT_FIXED_ONE 1
`define TMCR_BIT_REVERTIVE_SELECT 0
`define TMCR_BIT_TIE_MAIN 7
`define TMCR_BIT_OUT5_EN 6
`define TMCR_BIT_OUT4_EN 5
`define TMCR_BIT_OUT5B_EN 4
`define TMCR_BIT_OUT4B_EN 3
`define TMCR_BIT_OUT3B_FN 2

`define TMCR_RATE_CODE_T1E1 4'h1
`define TMCR_KHZ_E1 12'h800
`define TMCR_KHZ_T1 12'h608
`define TMCR_FORCE_AUTO_LO 4'h0
`define TMCR_FORCE_AUTO_HI 4'hf
`define TMCR_FORCE_IN6 4'h6
`define TMCR_FORCE_IN8 4'h8
`define TMCR_FORCE_IN9 4'h9

`define TMCR_CLK_HZ 32'd20000000
`define TMCR_ALARM_TIMEOUT_S 32'd128
`define TMCR_ALARM_TIMEOUT_CYC (`TMCR_ALARM_TIMEOUT_S * `TMCR_CLK_HZ)
`define TMCR_NUM_INPUTS 9

`endif

// ---- tmcr_regs.v ----
/*
 * Timing master configuration register bank: sync/holdover, auxiliary PLL,
 * legacy input format and output enable registers plus the control levels
 * they derive for the DPLL, synthesis and output logic.
 * Assumes the processor port and the DPLL status inputs are synchronous to
 * MCLK_I; only the rate select strap pin is asynchronous.
 * Every control output is a registered copy, so it lags its register by one
 * clock; downstream logic must tolerate that single-cycle delay.
 * Reset must be held for at least five edges so the strap has settled
 * before the rate select bit takes its default from it.
 */
`timescale 1ns/10ps
`include "tmcr_map.vh"

module tmcr_regs #(
    parameter [31:0] ALARM_TIMEOUT = `TMCR_ALARM_TIMEOUT_CYC
) (
    input wire MCLK_I,                  // Master clock, 20 MHz
    input wire RESET_I,                 // Synchronous reset, active high
    input wire [7:0] REG_ADDR_I,        // Register address
    input wire [7:0] REG_WDATA_I,       // Write data
    input wire REG_WR_I,                // Write strobe, one cycle
    input wire REG_RD_I,                // Read strobe, one cycle
    input wire RATE_SELECT_PIN_I,       // T1/E1 strap pin, asynchronous
    input wire [3:0] SYNC_SOURCE_I,     // Frame sync source field
    input wire [3:0] MAIN_SELECTED_REF_I, // Main DPLL selected reference
    input wire MAIN_LOCKED_I,           // Main DPLL in lock
    input wire [3:0] INPUT_RATE_CODE_I, // Rate code of the input being queried
    input wire AUX_APLL_SOURCE_I,       // Auxiliary APLL source bit
    input wire [8:0] PHASE_ALARM_SET_I, // Phase alarm raised, per input
    input wire [8:0] PHASE_ALARM_CANCEL_I, // Software cancel, per input
    output reg [7:0] REG_RDATA_O,       // Read data, valid cycle after strobe
    output reg EXT_SYNC_WATCH_O,        // Main DPLL watches frame sync pins
    output reg [8:0] PHASE_ALARM_O,     // Phase alarm state, per input
    output reg OSC_EDGE_FALLING_O,      // 1 = falling oscillator edge
    output reg ZERO_OFFSET_HOLDOVER_O,  // 1 = 0 ppm holdover
    output reg [11:0] NOMINAL_KHZ_O,    // T1/E1 rate for code 0001, else 0
    output reg MAIN_REVERTIVE_O,        // Main DPLL revertive
    output reg AUX_REVERTIVE_O,         // Auxiliary DPLL revertive, always 1
    output reg OUTPUTS_FROM_MAIN_O,     // Every output clock from main DPLL
    output reg AUX_APLL_FROM_MAIN_O,    // Auxiliary APLL locked to main DPLL
    output reg AUX_APLL_USE_INPUT_RATE_CODE_O,     // APLL rate from its frequency field
    output reg AUX_FORCE_ACTIVE_O,      // Auxiliary reference is forced
    output reg [3:0] AUX_FORCE_INPUT_O, // Forced input number, top slot
    output reg AUX_NO_SWITCH_O,         // Auxiliary DPLL must not switch
    output reg OUT5_ENABLE_O,           // Output 5 clocking
    output reg OUT4_ENABLE_O,           // Output 4 clocking
    output reg OUT5B_ENABLE_O,          // Output 5B clocking
    output reg OUT4B_ENABLE_O,          // Output 4B clocking
    output reg OUT3B_CLOCK_FN_O         // 1 = output 3B clock, 0 = general pin
);

    // ************************************************************
    // Strap synchroniser
    // ************************************************************
    reg strap_s1;
    reg strap_s2;
    reg strap_s3;
    reg strap;

    // Three stages guard against metastability; the strap is only a boot
    // level, so the extra latency costs nothing while reset is held.
    // Strap comes from a pin; value accepted once stages two and three agree
    always @(posedge MCLK_I) begin
        strap_s1 <= RATE_SELECT_PIN_I;
        strap_s2 <= strap_s1;
        strap_s3 <= strap_s2;
        if (strap_s2 == strap_s3) begin
            strap <= strap_s3;
        end
    end

    // ************************************************************
    // Register storage
    // ************************************************************
    reg [7:0] sync_and_holdover_config;
    reg [7:0] aux_pll_config;
    reg [7:0] legacy_input_format;
    reg [7:0] output_enable_config;
    reg [3:0] prev_selected_ref;
    // Write decode and the reference-change event for the auto clear
    wire wr_sync = REG_WR_I && (REG_ADDR_I == `TMCR_SYNC_HOLD_ADDR);
    wire ref_changed = (MAIN_SELECTED_REF_I != prev_selected_ref);
    wire src_group = (SYNC_SOURCE_I[3:2] == 2'b11);
    wire auto_gate = sync_and_holdover_config[`TMCR_BIT_AUTO_GATE];

    // Track the selected reference so a change is seen as an event.
    // Reset copies the live reference, so the first edge after release never
    // looks like a change and cannot clear the frame sync enable by itself.
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            prev_selected_ref <= MAIN_SELECTED_REF_I;
        end else begin
            prev_selected_ref <= MAIN_SELECTED_REF_I;
        end
    end

    // Defaults and writes
    // Registers only move on the clock edge, so enables never glitch.
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            sync_and_holdover_config <= `TMCR_SYNC_HOLD_RESET;
            // The strap is the synchronised pin, so a pin moving while reset
            // is held settles before the register takes it.
            // Strap loads default
            sync_and_holdover_config[`TMCR_BIT_RATE_SEL] <= strap;
            aux_pll_config <= `TMCR_AUX_PLL_RESET;
            legacy_input_format <= `TMCR_LEGACY_FMT_RESET;
            output_enable_config <= `TMCR_OUT_EN_RESET;
        end else begin
            if (wr_sync) begin
                sync_and_holdover_config <= REG_WDATA_I;
                // Bit 1 has no function and always reads one
                sync_and_holdover_config[`TMCR_BIT_FIXED_ONE] <= 1'b1;
            end else if (src_group && auto_gate && ref_changed) begin
                // Auto clear enable
                // A write in the same cycle wins so software intent is kept.
                sync_and_holdover_config[`TMCR_BIT_EXT_SYNC] <= 1'b0;
            end
            // Stored whole; the force field is decoded in the derived controls
            if (REG_WR_I && (REG_ADDR_I == `TMCR_AUX_PLL_ADDR)) begin
                aux_pll_config <= REG_WDATA_I;
            end
            if (REG_WR_I && (REG_ADDR_I == `TMCR_LEGACY_FMT_ADDR)) begin
                legacy_input_format <= REG_WDATA_I;
            end
            // Bit 7 has no function and always reads zero
            if (REG_WR_I && (REG_ADDR_I == `TMCR_OUT_EN_ADDR)) begin
                output_enable_config <= {1'b0, REG_WDATA_I[6:0]};
            end
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    reg [7:0] next_rdata;

    // Unmapped addresses read as zero
    always @* begin
        case (REG_ADDR_I)
            `TMCR_SYNC_HOLD_ADDR: next_rdata = sync_and_holdover_config;
            `TMCR_AUX_PLL_ADDR: next_rdata = aux_pll_config;
            `TMCR_LEGACY_FMT_ADDR: next_rdata = legacy_input_format;
            `TMCR_OUT_EN_ADDR: next_rdata = output_enable_config;
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data is captured on the strobe and held, so software may take it
    // at any time before the next read.
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (REG_RD_I) begin
            REG_RDATA_O <= next_rdata;
        end
    end

    // ************************************************************
    // Phase alarm timeout
    // ************************************************************
    wire autoclear = sync_and_holdover_config[`TMCR_BIT_AUTOCLEAR];
    wire [8:0] next_alarm;
    genvar gi;

    // Nine full-width counters cost area; a shared seconds prescaler would
    // save it, at the price of a timeout that is only accurate to a second.
    // The alarm stands ALARM_TIMEOUT cycles, its rising cycle counted first.
    generate
        for (gi = 0; gi < `TMCR_NUM_INPUTS; gi = gi + 1) begin : alarm_g
            reg [31:0] age;
            wire counting = PHASE_ALARM_O[gi] && autoclear;
            wire expire = counting && (age >= ALARM_TIMEOUT - 32'h1);
            wire restart = PHASE_ALARM_SET_I[gi] || PHASE_ALARM_CANCEL_I[gi];

            // Alarm cancel
            // A new raise beats a cancel arriving in the same cycle, so an
            // alarm that fires again is never lost to a stale cancel.
            assign next_alarm[gi] = PHASE_ALARM_SET_I[gi] ? 1'b1 :
                ((PHASE_ALARM_CANCEL_I[gi] || expire) ? 1'b0 : PHASE_ALARM_O[gi]);

            // One age counter per input; a raise or cancel restarts it, and
            // dropping autoclear mid-count starts the full timeout over.
            always @(posedge MCLK_I) begin
                if (RESET_I) begin
                    age <= 32'h0;
                end else if (restart || expire || !counting) begin
                    age <= 32'h0;
                end else begin
                    age <= age + 32'h1;
                end
            end
        end
    endgenerate

    // All nine alarm bits live in one register, so each has a single driver
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            PHASE_ALARM_O <= 9'h000;
        end else begin
            PHASE_ALARM_O <= next_alarm;
        end
    end

    // ************************************************************
    // Derived controls
    // ************************************************************
    // Field views of the stored registers
    wire ext_en = sync_and_holdover_config[`TMCR_BIT_EXT_SYNC];
    wire rate_sel = sync_and_holdover_config[`TMCR_BIT_RATE_SEL];
    wire tie_main = aux_pll_config[`TMCR_BIT_TIE_MAIN];
    wire [3:0] force_code = aux_pll_config[3:0];
    reg next_sync_watch;
    reg next_force;

    // Outside the 11XX group the gate also needs lock to the chosen source;
    // inside it the gate acts only through the auto clear of the enable bit.
    // Frame sync gating
    always @* begin
        if (!src_group && auto_gate) begin
            next_sync_watch = ext_en && MAIN_LOCKED_I && (MAIN_SELECTED_REF_I == SYNC_SOURCE_I);
        end else begin
            next_sync_watch = ext_en;
        end
    end

    // Force decode
    // Code 0111 and 1010-1110 are unused and act as automatic.
    // Falling back to automatic never forces a bogus input onto the DPLL.
    always @* begin
        case (force_code)
            `TMCR_FORCE_IN8: next_force = 1'b1;
            `TMCR_FORCE_IN9: next_force = 1'b1;
            default: next_force = (force_code != `TMCR_FORCE_AUTO_LO)
                && (force_code <= `TMCR_FORCE_IN6);
        endcase
    end

    // All control outputs come from flops
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            EXT_SYNC_WATCH_O <= 1'b0;
            OSC_EDGE_FALLING_O <= 1'b0;
            ZERO_OFFSET_HOLDOVER_O <= 1'b0;
            NOMINAL_KHZ_O <= 12'h000;
            MAIN_REVERTIVE_O <= 1'b0;
            AUX_REVERTIVE_O <= 1'b1;
            OUTPUTS_FROM_MAIN_O <= 1'b0;
            AUX_APLL_FROM_MAIN_O <= 1'b0;
            AUX_APLL_USE_INPUT_RATE_CODE_O <= 1'b0;
            AUX_FORCE_ACTIVE_O <= 1'b0;
            AUX_FORCE_INPUT_O <= 4'h0;
            AUX_NO_SWITCH_O <= 1'b0;
            OUT5_ENABLE_O <= 1'b0;
            OUT4_ENABLE_O <= 1'b0;
            OUT5B_ENABLE_O <= 1'b0;
            OUT4B_ENABLE_O <= 1'b0;
            OUT3B_CLOCK_FN_O <= 1'b0;
        end else begin
            EXT_SYNC_WATCH_O <= next_sync_watch;
            // The faster oscillator edge gives the lower jitter
            // Edge select
            OSC_EDGE_FALLING_O <= sync_and_holdover_config[`TMCR_BIT_OSC_EDGE];
            // Zero offset leaves accuracy to the external oscillator
            // Holdover mode
            ZERO_OFFSET_HOLDOVER_O <= sync_and_holdover_config[`TMCR_BIT_ZERO_HOLD];
            // Other codes report zero so downstream logic never sees a stale rate
            // T1/E1 rate
            if (INPUT_RATE_CODE_I == `TMCR_RATE_CODE_T1E1) begin
                NOMINAL_KHZ_O <= rate_sel ? `TMCR_KHZ_T1 : `TMCR_KHZ_E1;
            end else begin
                NOMINAL_KHZ_O <= 12'h000;
            end
            // Switching policy lives in the main DPLL; only the mode leaves here
            // Revertive select
            MAIN_REVERTIVE_O <= sync_and_holdover_config[`TMCR_BIT_REVERTIVE_SELECT];
            // No register bit stands behind this; it is one in and out of reset
            // Auxiliary always revertive
            AUX_REVERTIVE_O <= 1'b1;
            // Both follow one term: tied to main with the source bit clear
            // Tie to main
            OUTPUTS_FROM_MAIN_O <= tie_main && !AUX_APLL_SOURCE_I;
            AUX_APLL_USE_INPUT_RATE_CODE_O <= tie_main && !AUX_APLL_SOURCE_I;
            // Tying to main overrides the source bit, which matters only untied
            // APLL source choice
            AUX_APLL_FROM_MAIN_O <= tie_main || AUX_APLL_SOURCE_I;
            // Input number is zero whenever selection is automatic
            // Forced top slot
            AUX_FORCE_ACTIVE_O <= next_force;
            AUX_FORCE_INPUT_O <= next_force ? force_code : 4'h0;
            // Hold forced input
            // Monitors are untouched; only switching away is blocked.
            AUX_NO_SWITCH_O <= next_force;
            // Enables change only on a clock edge, so a pin never sees a runt
            // Output enables
            OUT5_ENABLE_O <= output_enable_config[`TMCR_BIT_OUT5_EN];
            OUT4_ENABLE_O <= output_enable_config[`TMCR_BIT_OUT4_EN];
            OUT5B_ENABLE_O <= output_enable_config[`TMCR_BIT_OUT5B_EN];
            OUT4B_ENABLE_O <= output_enable_config[`TMCR_BIT_OUT4B_EN];
            OUT3B_CLOCK_FN_O <= output_enable_config[`TMCR_BIT_OUT3B_FN];
        end
    end

endmodule

// ---- tmcr_sva.sv ----
/* Checker for the timing master configuration bank.
   Assumes it is bound to tmcr_regs: one clock, synchronous active high reset. */
`timescale 1ns/10ps
`include "tmcr_map.vh"
module tmcr_sva #(
    parameter [31:0] ALARM_TIMEOUT = 32'd16
) (
    input wire MCLK_I, // Clock
    input wire RESET_I, // Reset
    input wire [7:0] REG_ADDR_I, // Address
    input wire [7:0] REG_WDATA_I, // Write data
    input wire REG_WR_I, // Write strobe
    input wire [3:0] SYNC_SOURCE_I, // Sync source
    input wire [3:0] MAIN_SELECTED_REF_I, // Main reference
    input wire [3:0] INPUT_RATE_CODE_I, // Rate code
    input wire AUX_APLL_SOURCE_I, // APLL source
    input wire [8:0] PHASE_ALARM_SET_I, // Alarm raise
    input wire EXT_SYNC_WATCH_O, // Sync active
    input wire [8:0] PHASE_ALARM_O, // Alarm state
    input wire [11:0] NOMINAL_KHZ_O, // Nominal rate
    input wire AUX_REVERTIVE_O, // Aux revertive
    input wire OUTPUTS_FROM_MAIN_O, // Outputs from main
    input wire AUX_APLL_FROM_MAIN_O, // APLL on main
    input wire AUX_APLL_USE_INPUT_RATE_CODE_O, // APLL rate field
    input wire AUX_FORCE_ACTIVE_O, // Force active
    input wire [3:0] AUX_FORCE_INPUT_O, // Forced input
    input wire AUX_NO_SWITCH_O, // No switching
    input wire OUT5_ENABLE_O, // Out 5
    input wire OUT4_ENABLE_O, // Out 4
    input wire OUT5B_ENABLE_O, // Out 5B
    input wire OUT4B_ENABLE_O, // Out 4B
    input wire OUT3B_CLOCK_FN_O // Out 3B function
);
    // ****************************************
    // Helper logic and sequences
    // ****************************************
    wire wr34 = REG_WR_I && REG_ADDR_I == `TMCR_SYNC_HOLD_ADDR;
    wire wr37 = REG_WR_I && REG_ADDR_I == `TMCR_OUT_EN_ADDR;
    reg gate;
    reg ac;
    reg [31:0] high_cnt;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);
    // Shadows of the sync gate and autoclear bits, which never show at the ports
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            gate <= 1'b1;
            ac <= 1'b1;
        end else if (wr34) begin
            gate <= REG_WDATA_I[`TMCR_BIT_AUTO_GATE];
            ac <= REG_WDATA_I[`TMCR_BIT_AUTOCLEAR];
        end
    end
    // Cycles input 1 has stood in alarm with autoclear on and no new raise
    always @(posedge MCLK_I) begin
        if (RESET_I || !(PHASE_ALARM_O[0] && ac) || PHASE_ALARM_SET_I[0]) begin
            high_cnt <= 32'h0;
        end else begin
            high_cnt <= high_cnt + 32'h1;
        end
    end
    // A lone write, so the register is not overwritten before it shows
    sequence s_wr37;
        wr37 ##1 !wr37;
    endsequence
    // Reference moves under a gated 11XX source with no competing write
    sequence s_ref_move;
        gate && SYNC_SOURCE_I[3:2] == 2'b11 && !wr34 && !$past(RESET_I)
            && $changed(MAIN_SELECTED_REF_I);
    endsequence
    a_sync_clear: assert property (s_ref_move |-> ##2 !EXT_SYNC_WATCH_O)
        else $error("sync not dropped on reference change");
    a_out_enables: assert property (s_wr37 |=> {OUT5_ENABLE_O, OUT4_ENABLE_O,
        OUT5B_ENABLE_O, OUT4B_ENABLE_O, OUT3B_CLOCK_FN_O} == $past(REG_WDATA_I[6:2], 2))
        else $error("output enables do not follow write");
    a_aux_revertive_select: assert property (AUX_REVERTIVE_O)
        else $error("aux DPLL not revertive");
    a_tie_input_rate_code: assert property (OUTPUTS_FROM_MAIN_O |-> AUX_APLL_USE_INPUT_RATE_CODE_O
        && AUX_APLL_FROM_MAIN_O) else $error("tie to main incomplete");
    a_src_main: assert property (AUX_APLL_SOURCE_I |=> AUX_APLL_FROM_MAIN_O
        && !OUTPUTS_FROM_MAIN_O) else $error("APLL source ignored");
    a_force_hold: assert property (AUX_NO_SWITCH_O == AUX_FORCE_ACTIVE_O)
        else $error("no switch differs from force");
    a_force_num: assert property (AUX_FORCE_ACTIVE_O == (AUX_FORCE_INPUT_O != 4'h0))
        else $error("forced input number inconsistent");
    a_rate_code: assert property (INPUT_RATE_CODE_I != `TMCR_RATE_CODE_T1E1
        |=> NOMINAL_KHZ_O == 12'h000) else $error("rate given for other code");
    a_alarm_raise: assert property (PHASE_ALARM_SET_I != 9'h000
        |=> (PHASE_ALARM_O & $past(PHASE_ALARM_SET_I)) == $past(PHASE_ALARM_SET_I))
        else $error("alarm not raised");
    a_alarm_expiry: assert property (!PHASE_ALARM_O[0] || high_cnt < ALARM_TIMEOUT)
        else $error("alarm outlived its timeout");
endmodule
bind tmcr_regs tmcr_sva #(.ALARM_TIMEOUT(ALARM_TIMEOUT)) u_sva (
    .MCLK_I(MCLK_I), .RESET_I(RESET_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .SYNC_SOURCE_I(SYNC_SOURCE_I),
    .MAIN_SELECTED_REF_I(MAIN_SELECTED_REF_I), .INPUT_RATE_CODE_I(INPUT_RATE_CODE_I),
    .AUX_APLL_SOURCE_I(AUX_APLL_SOURCE_I), .PHASE_ALARM_SET_I(PHASE_ALARM_SET_I),
    .EXT_SYNC_WATCH_O(EXT_SYNC_WATCH_O), .PHASE_ALARM_O(PHASE_ALARM_O),
    .NOMINAL_KHZ_O(NOMINAL_KHZ_O), .AUX_REVERTIVE_O(AUX_REVERTIVE_O),
    .OUTPUTS_FROM_MAIN_O(OUTPUTS_FROM_MAIN_O), .AUX_APLL_FROM_MAIN_O(AUX_APLL_FROM_MAIN_O),
    .AUX_APLL_USE_INPUT_RATE_CODE_O(AUX_APLL_USE_INPUT_RATE_CODE_O), .AUX_FORCE_ACTIVE_O(AUX_FORCE_ACTIVE_O),
    .AUX_FORCE_INPUT_O(AUX_FORCE_INPUT_O), .AUX_NO_SWITCH_O(AUX_NO_SWITCH_O),
    .OUT5_ENABLE_O(OUT5_ENABLE_O), .OUT4_ENABLE_O(OUT4_ENABLE_O),
    .OUT5B_ENABLE_O(OUT5B_ENABLE_O), .OUT4B_ENABLE_O(OUT4B_ENABLE_O),
    .OUT3B_CLOCK_FN_O(OUT3B_CLOCK_FN_O));
